// [hdl/cio_pkg.sv]
// package: constants and types for the contact input/output run monitor
package cio_pkg;
   // ---------------------------------------------------------------
   // timing
   // ---------------------------------------------------------------
   localparam int CLK_MHZ = 200;
   localparam int TICK_US = 1000;
   localparam int TICK_CYCLES = CLK_MHZ * TICK_US;
   localparam int PULSE_HOLD_MS = 300;
   localparam int DELAY_W = 16;
   localparam logic [15:0] READ_DELAY_DEF = 16'h0000;
   localparam logic [15:0] OPEN_DET_DEF = 16'h0000;
   // ---------------------------------------------------------------
   // register map, word offsets as byte addresses
   // ---------------------------------------------------------------
   localparam logic [7:0] ADR_IN_CFG = 8'h00;
   localparam logic [7:0] ADR_OUT_CFG = 8'h04;
   localparam logic [7:0] ADR_MODE = 8'h08;
   localparam logic [7:0] ADR_RD_DELAY = 8'h0C;
   localparam logic [7:0] ADR_OPEN_DET = 8'h10;
   localparam logic [7:0] ADR_STATUS = 8'h14;
   localparam logic [7:0] ADR_IRQ_STAT = 8'h18;
   localparam logic [7:0] ADR_IRQ_CLR = 8'h1C;
   localparam logic [7:0] ADR_IRQ_EN = 8'h20;
   // ---------------------------------------------------------------
   // field encodings
   // ---------------------------------------------------------------
   // input function, 3 bits per input
   localparam logic [2:0] FN_OFF = 3'h0;
   localparam logic [2:0] FN_RUN_LVL = 3'h1;
   localparam logic [2:0] FN_RUN_PLS = 3'h2;
   localparam logic [2:0] FN_SW_NO = 3'h3;
   localparam logic [2:0] FN_SW_NC = 3'h4;
   localparam logic [2:0] FN_RMT_LVL = 3'h5;
   localparam logic [2:0] FN_RMT_PLS = 3'h6;
   localparam logic [5:0] IN_CFG_DEF = {FN_OFF, FN_RUN_LVL};
   // output function, 2 bits plus 1 polarity bit (1 = normally closed)
   localparam logic [1:0] OF_OFF = 2'h0;
   localparam logic [1:0] OF_RUN = 2'h1;
   localparam logic [1:0] OF_RMT = 2'h2;
   localparam logic [1:0] OF_ALM = 2'h3;
   localparam logic [8:0] OUT_CFG_DEF = {1'b1, OF_ALM, 1'b0, OF_RMT, 1'b0, OF_RUN};
   // communication mode
   localparam logic [2:0] CM_LOCAL = 3'h0;
   localparam logic [2:0] CM_DIO = 3'h1;
   localparam logic [2:0] CM_SERIAL_REG = 3'h2;
   localparam logic [2:0] CM_SIMPLE_1 = 3'h3;
   localparam logic [2:0] CM_SIMPLE_2 = 3'h4;
   // alarm response
   localparam logic [1:0] AR_STOP = 2'h0;
   localparam logic [1:0] AR_CONT = 2'h1;
   localparam logic [1:0] AR_NONE = 2'h2;
   // mode register fields
   localparam int MD_CM_LSB = 0;
   localparam int MD_AR_LSB = 3;
   localparam int MD_SW_RUN = 5;
   localparam logic [5:0] MODE_DEF = 6'h00;
   // interrupt bits
   localparam int IRQ_ALARM = 0;
   localparam int IRQ_START = 1;
   localparam int IRQ_STOP = 2;
   localparam int IRQ_N = 3;
   // monitor state
   typedef enum logic [1:0] {MS_IDLE = 2'b00, MS_DELAY = 2'b01, MS_WATCH = 2'b11} cio_mon_t;
endpackage

// [hdl/cio_run_monitor.sv]
// contact input/output logic: run/stop, remote select, switch monitor, outputs
module cio_run_monitor
   import cio_pkg::*;
#(
   parameter int TICK_DIV = TICK_CYCLES,
   parameter int HOLD_MS = PULSE_HOLD_MS
)
(
   input wire logic CLK,
   input wire logic RST_N,
   input wire logic [1:0] CONTACT_IN,
   input wire logic [7:0] ADDR,
   input wire logic [31:0] WDATA,
   input wire logic WR,
   input wire logic RD,
   output logic [31:0] RDATA,
   output logic [2:0] CONTACT_OUT,
   output logic RUNNING,
   output logic REMOTE,
   output logic IRQ
);
   // refuse timing values that the counters cannot hold
   if (TICK_DIV < 1 || HOLD_MS < 0 || HOLD_MS > 32'h0000_FFFF)
   begin : g_bad_param
      $error("bad timing parameter");
   end

   // ---------------------------------------------------------------
   // registers
   // ---------------------------------------------------------------
   logic [1:0] in_s1_r, in_s2_r, in_d_r;
   logic [31:0] tick_cnt_r;
   logic tick_r;
   logic [5:0] in_cfg_r;
   logic [8:0] out_cfg_r;
   logic [5:0] mode_r;
   logic [15:0] rd_delay_r, open_det_r;
   logic run_r, rmt_r, alarm_r;
   logic [IRQ_N-1:0] irq_stat_r, irq_en_r;
   logic [15:0] hold_cnt_r [2];
   logic [15:0] open_cnt_r [2];
   logic [15:0] dly_cnt_r;
   cio_mon_t mon_r;

   // ---------------------------------------------------------------
   // input synchroniser and millisecond tick
   // ---------------------------------------------------------------
   // two-stage sync
   always_ff @(posedge CLK)
   begin
      in_s1_r <= CONTACT_IN;
      in_s2_r <= in_s1_r;
      in_d_r <= in_s2_r;
   end

   always_ff @(posedge CLK)
   begin
      if (!RST_N || tick_cnt_r == 32'(TICK_DIV - 1))
         tick_cnt_r <= 32'h0000_0000;
      else
         tick_cnt_r <= tick_cnt_r + 32'h0000_0001;
      tick_r <= RST_N && tick_cnt_r == 32'(TICK_DIV - 1);
   end

   // ---------------------------------------------------------------
   // per input decode: release detection, hold timer, switch timers
   // ---------------------------------------------------------------
   wire [2:0] fn [2];
   wire [1:0] rel, pulse_ok, sw_en, sw_open, sw_fault, run_lvl_sel, rmt_lvl_sel;
   wire [1:0] run_pls_ev, rmt_pls_ev;
   wire [2:0] cmode = mode_r[MD_CM_LSB +: 3];
   wire [1:0] aresp = mode_r[MD_AR_LSB +: 2];
   wire watching = (mon_r == MS_WATCH);
   // switch 1 allowed only in some modes
   wire sw1_mode = (cmode == CM_LOCAL) || (cmode == CM_SERIAL_REG) || (cmode == CM_SIMPLE_1);

   genvar g;
   generate
      for (g = 0; g < 2; g++)
      begin : g_in
         assign fn[g] = in_cfg_r[3*g +: 3];
         assign rel[g] = in_d_r[g] && !in_s2_r[g];
         // releases after short holds are not trusted
         assign pulse_ok[g] = rel[g] && (hold_cnt_r[g] >= 16'(HOLD_MS));
         assign run_lvl_sel[g] = (fn[g] == FN_RUN_LVL);
         assign rmt_lvl_sel[g] = (fn[g] == FN_RMT_LVL);
         assign run_pls_ev[g] = (fn[g] == FN_RUN_PLS) && pulse_ok[g];
         assign rmt_pls_ev[g] = (fn[g] == FN_RMT_PLS) && pulse_ok[g];
         assign sw_en[g] = ((fn[g] == FN_SW_NO) || (fn[g] == FN_SW_NC)) && (g == 1 || sw1_mode);
         // polarity: NO switch open when low, NC open when high
         assign sw_open[g] = (fn[g] == FN_SW_NC) ? in_s2_r[g] : !in_s2_r[g];
         // open only after continuous open time
         assign sw_fault[g] = sw_en[g] && watching && sw_open[g] && (open_cnt_r[g] >= open_det_r);

         // hold time counted in ms ticks
         always_ff @(posedge CLK)
         begin
            if (!RST_N || !in_s2_r[g])
               hold_cnt_r[g] <= 16'h0000;
            else if (tick_r && hold_cnt_r[g] != 16'hFFFF)
               hold_cnt_r[g] <= hold_cnt_r[g] + 16'h0001;
         end

         // open-time counter restarts whenever the switch closes
         always_ff @(posedge CLK)
         begin
            if (!RST_N || !sw_open[g] || !watching)
               open_cnt_r[g] <= 16'h0000;
            else if (tick_r && open_cnt_r[g] != 16'hFFFF)
               open_cnt_r[g] <= open_cnt_r[g] + 16'h0001;
         end
      end
   endgenerate

   // ---------------------------------------------------------------
   // run / remote control
   // ---------------------------------------------------------------
   // contact control only when a run function exists
   wire has_run = run_lvl_sel[0] | run_lvl_sel[1] | (fn[0] == FN_RUN_PLS) | (fn[1] == FN_RUN_PLS);
   wire any_fault = |sw_fault;
   wire alarm_ev = any_fault && (aresp != AR_NONE) && !alarm_r;
   wire stop_alarm = alarm_ev && (aresp == AR_STOP);
   logic run_nxt, rmt_nxt;
   // a latched stop alarm keeps a fresh start from taking effect
   wire start_block = alarm_r && (aresp == AR_STOP) && run_nxt && !run_r;
   wire run_upd = run_nxt && !start_block;

   always_comb
   begin
      run_nxt = run_r;
      if (!has_run)
         run_nxt = mode_r[MD_SW_RUN];
      else if (|run_lvl_sel)
         run_nxt = |(run_lvl_sel & in_s2_r);
      else if (|run_pls_ev)
         run_nxt = !run_r;
      if (stop_alarm)
         run_nxt = 1'b0;
   end

   always_comb
   begin
      rmt_nxt = rmt_r;
      if (cmode != CM_DIO)
         rmt_nxt = 1'b0;
      else if (|rmt_lvl_sel)
         rmt_nxt = |(rmt_lvl_sel & in_s2_r);
      else if (|rmt_pls_ev)
         rmt_nxt = !rmt_r;
   end

   // alarm latches until bit 0 is written to ADR_IRQ_CLR, run state updates
   always_ff @(posedge CLK)
   begin
      if (!RST_N)
      begin
         run_r <= 1'b0;
         rmt_r <= 1'b0;
         alarm_r <= 1'b0;
      end
      else
      begin
         run_r <= run_upd;
         rmt_r <= rmt_nxt;
         if (alarm_ev)
            alarm_r <= 1'b1;
         else if (WR && ADDR == ADR_IRQ_CLR && WDATA[IRQ_ALARM])
            alarm_r <= 1'b0;
      end
   end

   // ---------------------------------------------------------------
   // monitor state machine
   // ---------------------------------------------------------------
   // delay after start, idle whenever stopped
   always_ff @(posedge CLK)
   begin
      if (!RST_N || !run_r)
      begin
         mon_r <= MS_IDLE;
         dly_cnt_r <= 16'h0000;
      end
      else
      begin
         case (mon_r)
            MS_IDLE:
            begin
               mon_r <= (rd_delay_r == 16'h0000) ? MS_WATCH : MS_DELAY;
               dly_cnt_r <= 16'h0000;
            end
            MS_DELAY:
            begin
               if (dly_cnt_r >= rd_delay_r)
                  mon_r <= MS_WATCH;
               else if (tick_r)
                  dly_cnt_r <= dly_cnt_r + 16'h0001;
            end
            MS_WATCH:
               mon_r <= MS_WATCH;
            default:
               mon_r <= MS_IDLE;
         endcase
      end
   end

   // ---------------------------------------------------------------
   // contact outputs
   // ---------------------------------------------------------------
   logic [2:0] out_nxt;
   generate
      for (g = 0; g < 3; g++)
      begin : g_out
         wire [1:0] ofn = out_cfg_r[3*g +: 2];
         wire cond = (ofn == OF_RUN) ? run_r : (ofn == OF_RMT) ? rmt_r :
                     (ofn == OF_ALM) ? alarm_r : 1'b0;
         assign out_nxt[g] = cond ^ out_cfg_r[3*g + 2];
      end
   endgenerate

   // ---------------------------------------------------------------
   // register bus and interrupts
   // ---------------------------------------------------------------
   wire wr_in = WR && ADDR == ADR_IN_CFG;
   wire wr_out = WR && ADDR == ADR_OUT_CFG;
   wire wr_mode = WR && ADDR == ADR_MODE;
   wire wr_dly = WR && ADDR == ADR_RD_DELAY;
   wire wr_odt = WR && ADDR == ADR_OPEN_DET;
   wire wr_clr = WR && ADDR == ADR_IRQ_CLR;
   wire wr_en = WR && ADDR == ADR_IRQ_EN;
   wire [IRQ_N-1:0] irq_ev = {!run_upd && run_r, run_upd && !run_r, alarm_ev};
   wire [31:0] rd_mux =
      (ADDR == ADR_IN_CFG) ? {26'h0, in_cfg_r} :
      (ADDR == ADR_OUT_CFG) ? {23'h0, out_cfg_r} :
      (ADDR == ADR_MODE) ? {26'h0, mode_r} :
      (ADDR == ADR_RD_DELAY) ? {16'h0, rd_delay_r} :
      (ADDR == ADR_OPEN_DET) ? {16'h0, open_det_r} :
      (ADDR == ADR_STATUS) ? {25'h0, in_s2_r, mon_r, alarm_r, rmt_r, run_r} :
      (ADDR == ADR_IRQ_STAT) ? {29'h0, irq_stat_r} :
      (ADDR == ADR_IRQ_EN) ? {29'h0, irq_en_r} : 32'h0000_0000;

   always_ff @(posedge CLK)
   begin
      if (!RST_N)
      begin
         in_cfg_r <= IN_CFG_DEF;
         out_cfg_r <= OUT_CFG_DEF;
         mode_r <= MODE_DEF;
         rd_delay_r <= READ_DELAY_DEF;
         open_det_r <= OPEN_DET_DEF;
         irq_en_r <= 3'h0;
      end
      else
      begin
         if (wr_in) in_cfg_r <= WDATA[5:0];
         if (wr_out) out_cfg_r <= WDATA[8:0];
         if (wr_mode) mode_r <= WDATA[5:0];
         if (wr_dly) rd_delay_r <= WDATA[15:0];
         if (wr_odt) open_det_r <= WDATA[15:0];
         if (wr_en) irq_en_r <= WDATA[IRQ_N-1:0];
      end
   end

   // sticky status, set wins over clear; read data and outputs
   always_ff @(posedge CLK)
   begin
      if (!RST_N)
      begin
         irq_stat_r <= 3'h0;
         RDATA <= 32'h0000_0000;
         CONTACT_OUT <= 3'h0;
         RUNNING <= 1'b0;
         REMOTE <= 1'b0;
         IRQ <= 1'b0;
      end
      else
      begin
         irq_stat_r <= (irq_stat_r & ~(wr_clr ? WDATA[IRQ_N-1:0] : 3'h0)) | irq_ev;
         RDATA <= RD ? rd_mux : 32'h0000_0000;
         CONTACT_OUT <= out_nxt;
         RUNNING <= run_r;
         REMOTE <= rmt_r;
         IRQ <= |(irq_stat_r & irq_en_r);
      end
   end

   // ---------------------------------------------------------------
   // assertions
   // ---------------------------------------------------------------
   sequence s_stopped;
      !run_r;
   endsequence

   mon_idle_a:
      assert property (@(posedge CLK) disable iff (!RST_N) s_stopped |=> mon_r == MS_IDLE)
      else $error("monitor active while stopped");
   level_run_a:
      assert property (@(posedge CLK) disable iff (!RST_N)
         run_lvl_sel[0] && !run_lvl_sel[1] && (fn[1] != FN_RUN_PLS) && !stop_alarm
         && !(alarm_r && aresp == AR_STOP)
         |=> run_r == $past(in_s2_r[0]))
      else $error("level run does not follow contact");
   pulse_run_a:
      assert property (@(posedge CLK) disable iff (!RST_N)
         !(|run_lvl_sel) && (|run_pls_ev) && !stop_alarm && !alarm_r |=> run_r != $past(run_r))
      else $error("pulse run did not toggle");
   rmt_toggle_a:
      assert property (@(posedge CLK) disable iff (!RST_N)
         cmode == CM_DIO && !(|rmt_lvl_sel) && (|rmt_pls_ev) |=> rmt_r != $past(rmt_r))
      else $error("pulse remote did not toggle");
   alarm_stop_a:
      assert property (@(posedge CLK) disable iff (!RST_N) stop_alarm |=> !run_r ##1 !RUNNING)
      else $error("stop alarm did not stop");
   no_detect_a:
      assert property (@(posedge CLK) disable iff (!RST_N) aresp == AR_NONE |-> !alarm_ev)
      else $error("alarm raised while disabled");
   sw1_gate_a:
      assert property (@(posedge CLK) disable iff (!RST_N) cmode == CM_DIO |-> !sw_fault[0])
      else $error("switch 1 monitored in contact mode");
   delay_wait_a:
      assert property (@(posedge CLK) disable iff (!RST_N)
         $rose(run_r) && rd_delay_r != 16'h0000 |=> mon_r == MS_DELAY)
      else $error("reading delay skipped");
   out_map_a:
      assert property (@(posedge CLK) disable iff (!RST_N)
         out_cfg_r[2:0] == {1'b0, OF_RUN} && $stable(out_cfg_r) |=> CONTACT_OUT[0] == $past(run_r))
      else $error("output 1 does not show run");
   irq_level_a:
      assert property (@(posedge CLK) disable iff (!RST_N)
         |(irq_stat_r & irq_en_r) |=> IRQ)
      else $error("interrupt not raised");
endmodule

// [tb/cio_contact_partner.sv]
// customer contacts: relays and switches driving the two contact inputs
module cio_contact_partner
#(
   parameter int HOLD_CYC = 60
)
(
   input wire logic clk,
   output logic [1:0] contact
);
   timeunit 1ns;
   timeprecision 1ps;
   initial contact = 2'h0;
   // move one contact just after a clock edge
   task automatic set_level(input int idx, input logic lvl);
      @(posedge clk);
      contact[idx] <= lvl;
   endtask
   task automatic pulse(input int idx);
      set_level(idx, 1'b1);
      repeat (HOLD_CYC) @(posedge clk);
      contact[idx] <= 1'b0;
      repeat (HOLD_CYC) @(posedge clk);
   endtask
endmodule

// [tb/cio_run_monitor_tb_top.sv]
// testbench top: bus tasks, contact scenarios, queued read checking
module cio_run_monitor_tb_top
   import cio_pkg::*;
();
   timeunit 1ns;
   timeprecision 1ps;
   localparam int TICK = 10;
   localparam int HOLD = 4;
   logic clk;
   logic rst_n;
   logic [1:0] contact_in;
   logic [7:0] addr;
   logic [31:0] wdata;
   logic wr;
   logic rd;
   logic [31:0] rdata;
   logic [2:0] contact_out;
   logic running;
   logic remote;
   logic irq;
   logic rd_seen = 1'b0;
   logic [63:0] note;
   logic [63:0] exp_q[$];
   logic [7:0] reg_adr [7] = '{ADR_IN_CFG, ADR_OUT_CFG, ADR_MODE, ADR_RD_DELAY, ADR_OPEN_DET,
      ADR_IRQ_STAT, ADR_IRQ_EN};
   logic [31:0] reg_def [7] = '{32'(IN_CFG_DEF), 32'(OUT_CFG_DEF), 32'(MODE_DEF),
      32'(READ_DELAY_DEF), 32'(OPEN_DET_DEF), 32'h0, 32'h0};
   logic [2:0] cms [5] = '{CM_LOCAL, CM_DIO, CM_SERIAL_REG, CM_SIMPLE_1, CM_SIMPLE_2};
   logic [4:0] cm_alarm = 5'h0D;
   int err_count = 0;
   int compares = 0;
   int rd_ms;
   int od_ms;
   cio_run_monitor #(.TICK_DIV(TICK), .HOLD_MS(HOLD)) i_dut (.CLK(clk), .RST_N(rst_n),
      .CONTACT_IN(contact_in), .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd), .RDATA(rdata),
      .CONTACT_OUT(contact_out), .RUNNING(running), .REMOTE(remote), .IRQ(irq));
   cio_contact_partner #(.HOLD_CYC((HOLD + 2) * TICK)) i_part (.clk(clk), .contact(contact_in));
   // ---------------------------------------------------------------
   // clock, compare and bus tasks
   // ---------------------------------------------------------------
   initial
   begin
      clk = 1'b0;
      forever
      begin
         #2.5 clk = ~clk;
      end
   end
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp)
      begin
         err_count++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic stop_test();
      $display("compares %0d err_count %0d", compares, err_count);
      if (err_count == 0 && compares > 0)
      begin
         $display("All checks passed");
      end
      else
      begin
         $display("Checks failed");
      end
      $finish;
   endtask
   task automatic bus_wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask
   // note the expected word and mask, then issue the read
   task automatic bus_rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      exp_q.push_back({m, e});
      @(posedge clk);
      rd <= 1'b0;
   endtask
   // read data stand in the cycle after the strobe
   always @(posedge clk)
   begin
      rd_seen <= rd;
   end
   always @(negedge clk)
   begin
      if (rd_seen === 1'b1)
      begin
         note = exp_q.pop_front();
         check(rdata & note[63:32], note[31:0]);
      end
   end
   // bounded wait on running (0) or remote (1)
   task automatic wait_out(input int which, input logic v);
      int n = 0;
      while (((which == 0) ? running : remote) !== v)
      begin
         @(posedge clk);
         #1;
         n++;
         if (n > 400)
         begin
            err_count++;
            stop_test();
         end
      end
   endtask
   // one monitored run: status before and after the delay plus open time
   task automatic sw_case(input logic [5:0] cfg, input logic [5:0] md, input int ri,
      input int si, input logic sl, input logic ea, input logic er);
      bus_wr(ADR_IN_CFG, 32'(cfg));
      bus_wr(ADR_MODE, 32'(md));
      i_part.set_level(si, sl);
      if (ri >= 0)
      begin
         i_part.set_level(ri, 1'b1);
      end
      wait_out(0, 1'b1);
      repeat ((rd_ms + od_ms - 2) * TICK - 4) @(posedge clk);
      bus_rd(ADR_STATUS, 32'h1, 32'h5);
      repeat ((rd_ms + od_ms + 2) * TICK) @(posedge clk);
      bus_rd(ADR_STATUS, {29'h0, ea, 1'b0, er}, 32'h5);
      check(32'(irq), 32'(ea));
      check(32'(contact_out), {29'h0, ~ea, 1'b0, er});
      if (ri >= 0)
      begin
         i_part.set_level(ri, 1'b0);
      end
      else
      begin
         bus_wr(ADR_MODE, 32'(md & 6'h1F));
      end
      wait_out(0, 1'b0);
      bus_wr(ADR_IRQ_CLR, 32'h7);
   endtask
   // ---------------------------------------------------------------
   // main sequence
   // ---------------------------------------------------------------
   initial
   begin
      rst_n = 1'b0;
      addr = 8'h00;
      wdata = 32'h0;
      wr = 1'b0;
      rd = 1'b0;
      void'($urandom(32'h3186811c));
      rd_ms = 2 + int'($urandom % 3);
      od_ms = 2 + int'($urandom % 3);
      repeat (4) @(posedge clk);
      rst_n <= 1'b1;
      repeat (2) @(posedge clk);
      #1;
      check(32'(contact_out), 32'h4);
      foreach (reg_adr[i])
      begin
         bus_rd(reg_adr[i], reg_def[i], 32'hFFFFFFFF);
      end
      bus_wr(8'h24, $urandom);
      bus_rd(8'h24, 32'h0, 32'hFFFFFFFF);
      bus_wr(ADR_IRQ_EN, 32'h7);
      i_part.set_level(0, 1'b1);
      wait_out(0, 1'b1);
      check(32'(contact_out), 32'h5);
      check(32'(irq), 32'h1);
      bus_rd(ADR_IRQ_STAT, 32'h2, 32'h7);
      bus_wr(ADR_OUT_CFG, 32'(OUT_CFG_DEF | 9'h004));
      repeat (3) @(posedge clk);
      check(32'(contact_out), 32'h4);
      bus_wr(ADR_OUT_CFG, 32'(OUT_CFG_DEF));
      bus_wr(ADR_IRQ_CLR, 32'h7);
      repeat (3) @(posedge clk);
      check(32'(irq), 32'h0);
      i_part.set_level(0, 1'b0);
      wait_out(0, 1'b0);
      bus_rd(ADR_IRQ_STAT, 32'h4, 32'h7);
      bus_wr(ADR_IN_CFG, 32'({FN_OFF, FN_RUN_PLS}));
      i_part.pulse(0);
      check(32'(running), 32'h1);
      i_part.pulse(0);
      check(32'(running), 32'h0);
      bus_wr(ADR_MODE, 32'(CM_DIO));
      bus_wr(ADR_IN_CFG, 32'({FN_RMT_LVL, FN_RUN_LVL}));
      i_part.set_level(1, 1'b1);
      wait_out(1, 1'b1);
      check(32'(contact_out), 32'h6);
      i_part.set_level(1, 1'b0);
      wait_out(1, 1'b0);
      bus_wr(ADR_IN_CFG, 32'({FN_RMT_PLS, FN_RUN_LVL}));
      i_part.pulse(1);
      check(32'(remote), 32'h1);
      i_part.pulse(1);
      check(32'(remote), 32'h0);
      bus_wr(ADR_IN_CFG, 32'h0);
      bus_wr(ADR_MODE, 32'h0);
      i_part.set_level(0, 1'b1);
      repeat (40) @(posedge clk);
      check(32'(running), 32'h0);
      i_part.set_level(0, 1'b0);
      bus_wr(ADR_IRQ_CLR, 32'h7);
      bus_wr(ADR_IRQ_EN, 32'h1);
      bus_wr(ADR_RD_DELAY, 32'(rd_ms));
      bus_wr(ADR_OPEN_DET, 32'(od_ms));
      sw_case({FN_SW_NO, FN_RUN_LVL}, {1'b0, AR_STOP, CM_LOCAL}, 0, 1, 1'b0, 1'b1, 1'b0);
      sw_case({FN_SW_NO, FN_RUN_LVL}, {1'b0, AR_CONT, CM_LOCAL}, 0, 1, 1'b0, 1'b1, 1'b1);
      sw_case({FN_SW_NO, FN_RUN_LVL}, {1'b0, AR_NONE, CM_LOCAL}, 0, 1, 1'b0, 1'b0, 1'b1);
      sw_case({FN_SW_NO, FN_RUN_LVL}, {1'b0, AR_STOP, CM_LOCAL}, 0, 1, 1'b1, 1'b0, 1'b1);
      i_part.set_level(1, 1'b0);
      repeat ((rd_ms + od_ms + 2) * TICK) @(posedge clk);
      bus_rd(ADR_STATUS, 32'h0, 32'h5);
      foreach (cms[i])
      begin
         sw_case({FN_RUN_LVL, FN_SW_NC}, {3'h0, cms[i]}, 1, 0, 1'b1, cm_alarm[i],
            ~cm_alarm[i]);
      end
      i_part.set_level(1, 1'b0);
      sw_case({FN_SW_NC, FN_SW_NO}, 6'h20, -1, 0, 1'b0, 1'b1, 1'b0);
      i_part.set_level(0, 1'b1);
      sw_case({FN_SW_NC, FN_SW_NO}, 6'h20, -1, 1, 1'b1, 1'b1, 1'b0);
      repeat (4) @(posedge clk);
      stop_test();
   end
   initial
   begin
      #400000;
      err_count++;
      stop_test();
   end
endmodule
